// File: iss_pkg.sv
/*
  Package for the two-wire sub-addressed slave with ship-and-store control.
  Holds bus addresses, sub address map, field positions, reset values and
  filter timing. Assumes a 100 MHz system clock.
*/
package iss_pkg;

  // Bus addresses as 8-bit words, direction in bit 0.
  localparam logic [7:0] ISS_ADDR_WR       = 8'h12;
  localparam logic [7:0] ISS_ADDR_RD       = 8'h13;

  // Sub address map.
  localparam logic [7:0] ISS_SUB_CMD0      = 8'h00;
  localparam logic [7:0] ISS_SUB_CMD1      = 8'h01;
  localparam logic [7:0] ISS_SUB_CMD2      = 8'h02;
  localparam logic [7:0] ISS_SUB_STAT0     = 8'h03;
  localparam logic [7:0] ISS_SUB_STAT1     = 8'h04;
  localparam logic [7:0] ISS_SUB_STAT2     = 8'h05;
  localparam logic [7:0] ISS_SUB_DISARM    = 8'h06;
  localparam logic [7:0] ISS_SUB_ARM       = 8'h07;

  // Command and status register counts and reset values.
  localparam int         ISS_NUM_CMD       = 4;
  localparam int         ISS_NUM_STAT      = 3;
  localparam logic [7:0] ISS_CMD_RESET     = 8'h00;
  localparam logic [7:0] ISS_PTR_RESET     = 8'h00;

  // Frame layout: eight data bits, then the acknowledge slot.
  localparam logic [3:0] ISS_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ISS_ACK_SLOT      = 4'h8;

  // Input filter: three-stage sampler, agreement of stages two and three.
  localparam int         ISS_SYNC_STAGES   = 3;

  // Bus timing basis.
  localparam int         ISS_CLK_MHZ       = 100;
  localparam int         ISS_BUS_MAX_KHZ   = 400;
  localparam int         ISS_SCL_HALF_NS   = 1250;
  localparam int         ISS_SCL_HALF_CYC  = (ISS_SCL_HALF_NS * ISS_CLK_MHZ) / 1000;

  // Glitch filter length in cycles, far below a fast-mode half period.
  localparam int         ISS_GLITCH_CYC    = 5;

  // Receiver states.
  typedef enum logic [2:0] {
    ISS_IDLE,
    ISS_ADDR,
    ISS_ADDR_ACK,
    ISS_WR_BYTE,
    ISS_WR_ACK,
    ISS_RD_BYTE,
    ISS_RD_ACK,
    ISS_RD_DONE
  } iss_state_t;

endpackage

// File: iss_in_filter.sv
/*
  Input conditioner for one bus line: a three-flop sampler followed by a
  glitch filter that only moves its output after a stable run.
  Assumes the input is asynchronous to clk.
*/
module iss_in_filter import iss_pkg::*; #(
  parameter int FILT_CYC = ISS_GLITCH_CYC
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic sys_rst,
  // Raw line and cleaned level.
  input  wire logic line_in,
  output logic      line_out
);

  logic [ISS_SYNC_STAGES-1:0] sync_reg;
  logic [ISS_SYNC_STAGES-1:0] sync_next;
  logic [3:0]                 cnt_reg;
  logic [3:0]                 cnt_next;
  logic                       out_reg;
  logic                       out_next;
  logic                       agree;

  // The first stage only feeds the second; stages two and three vote.
  always_comb begin
    sync_next = {sync_reg[ISS_SYNC_STAGES-2:0], line_in};
    agree     = (sync_reg[1] == sync_reg[2]);
    cnt_next  = 4'h0;
    out_next  = out_reg;
    if (agree && (sync_reg[2] != out_reg)) begin
      cnt_next = cnt_reg + 4'h1;
      if (cnt_reg == 4'(FILT_CYC - 1)) begin
        out_next = sync_reg[2];
        cnt_next = 4'h0;
      end
    end
  end

  // Idle bus level is high, so reset to released.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_reg <= '1;
      cnt_reg  <= 4'h0;
      out_reg  <= 1'b1;
    end else begin
      sync_reg <= sync_next;
      cnt_reg  <= cnt_next;
      out_reg  <= out_next;
    end
  end

  assign line_out = out_reg;

endmodule

// File: iss_regfile.sv
/*
  Command register file: pending and active copies of the four writable
  command locations, plus a changed flag per location.
  Assumes write and commit strobes come from the serial engine on clk.
*/
module iss_regfile import iss_pkg::*; #(
  parameter int N = ISS_NUM_CMD
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Pending write port.
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_idx,
  input  wire logic [7:0] wr_data,
  // Commit all pending data.
  input  wire logic       commit,
  // Registered read port.
  input  wire logic [1:0] rd_idx,
  output logic      [7:0] rd_data,
  // Active contents, flattened.
  output logic [N*8-1:0]  active_flat
);

  logic [7:0] pend_reg [N];
  logic [7:0] pend_next[N];
  logic [7:0] act_reg  [N];
  logic [7:0] act_next [N];
  logic [N-1:0] chg_reg;
  logic [N-1:0] chg_next;
  logic [7:0] rd_reg;
  logic [7:0] rd_next;

  // Writes go to pending only; a commit copies every location at once.
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pend_next[i] = pend_reg[i];
      act_next[i]  = act_reg[i];
      chg_next[i]  = chg_reg[i];
      if (commit) begin
        act_next[i] = pend_reg[i];                                // [RULE_19]
        chg_next[i] = 1'b0;
      end
      if (wr_en && (wr_idx == 2'(i))) begin
        pend_next[i] = wr_data;                                   // [RULE_17]
        chg_next[i]  = 1'b1;
      end
    end
    // A changed location reads its pending value.
    rd_next = chg_reg[rd_idx] ? pend_reg[rd_idx] : act_reg[rd_idx]; // [RULE_21]
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < N; i++) begin
        pend_reg[i] <= ISS_CMD_RESET;                             // [RULE_06]
        act_reg[i]  <= ISS_CMD_RESET;
      end
      chg_reg <= '0;
      rd_reg  <= 8'h00;
    end else begin
      for (int i = 0; i < N; i++) begin
        pend_reg[i] <= pend_next[i];
        act_reg[i]  <= act_next[i];
      end
      chg_reg <= chg_next;
      rd_reg  <= rd_next;
    end
  end

  assign rd_data = rd_reg;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_flat
      assign active_flat[g*8 +: 8] = act_reg[g];
    end
  endgenerate

endmodule

// File: iss_slave.sv
/*
  Two-wire sub-addressed slave with staged command registers and the
  ship-and-store arming logic. Top module of the block.
  Assumes SDA and SCL arrive from pins through pull-ups, asynchronous to
  clk, and that sys_rst is driven by the logic-supply undervoltage lockout.
*/
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [RULE_01] Full acked write to 0x07 arms ship mode.
// [RULE_02] Armed mode activates once input power absent.
// [RULE_03] Reading pointer 0x07 leaves ship state alone.
// [RULE_04] Input power or 0x06 write leaves mode.
// [RULE_05] Active mode drives battery gate off.
// [RULE_06] Supply lockout resets port and configuration.
// [RULE_07] Works to 400kHz, filters input glitches.
// [RULE_08] START/STOP are SDA edges with SCL high.
// [RULE_09] Eight bits MSB first, then acknowledge.
// [RULE_10] Never drives SCL, no clock stretching.
// [RULE_11] Ack write bytes; in reads only address.
// [RULE_12] Receiver holds SDA low during ack high.
// [RULE_13] Read sends one byte, then releases SDA.
// [RULE_14] Answers 0x12 write and 0x13 read.
// [RULE_15] Four command and three status registers.
// [RULE_16] First byte loads pointer, which persists.
// [RULE_17] Odd bytes set pointer, even bytes pending.
// [RULE_18] Repeated START keeps pending data unapplied.
// [RULE_19] STOP commits all pending data at once.
// [RULE_20] Master idles lines high, owns SCL falls.
// [RULE_21] Changed pending value is what reads return.
// [RULE_22] Extra read clocks see SDA released high.
// [RULE_23] Only 0x00-0x02, 0x06-0x07 are writable.
// [RULE_24] Non-writable data bytes acked, then discarded.
// [RULE_25] Bus inputs sampled and filtered before decode.
module iss_slave import iss_pkg::*; #(
  parameter int FILT_CYC = ISS_GLITCH_CYC
) (
  // Clock and reset from the supply lockout.
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Serial bus; SCL is input only.
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Power monitors and status inputs.
  input  wire logic        input_power_good,
  input  wire logic [23:0] status_flat,
  // Ship-and-store control.
  output logic             ship_armed,
  output logic             ship_active,
  output logic             batt_gate_off,
  // Active command register contents.
  output logic [31:0]      cmd_active
);

  //////////////////////////////////////////////////////////////////////////
  // Input conditioning.

  logic scl_f;
  logic sda_f;
  logic scl_d_reg;
  logic sda_d_reg;

  iss_in_filter #(.FILT_CYC(FILT_CYC)) u_scl_filt (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .line_in  (scl_in),
    .line_out (scl_f)
  );                                                              // [RULE_25]

  iss_in_filter #(.FILT_CYC(FILT_CYC)) u_sda_filt (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .line_in  (sda_in),
    .line_out (sda_f)
  );                                                              // [RULE_07]

  // Delayed copies for edge detection on the filtered lines.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Bus conditions; SDA may only move with SCL high for START or STOP.
  assign scl_rise  = scl_f & ~scl_d_reg;
  assign scl_fall  = ~scl_f & scl_d_reg;
  assign start_det = scl_f & scl_d_reg & sda_d_reg & ~sda_f;     // [RULE_08]
  assign stop_det  = scl_f & scl_d_reg & ~sda_d_reg & sda_f;     // [RULE_08]

  //////////////////////////////////////////////////////////////////////////
  // Sub address decode.

  // Map a writable sub address to its register index.
  function automatic logic [1:0] cmd_index(input logic [7:0] sub);
    cmd_index = (sub == ISS_SUB_DISARM) ? 2'h3 : sub[1:0];
  endfunction

  // Writable locations are the command registers and the two ship controls.
  function automatic logic is_writable(input logic [7:0] sub);
    is_writable = (sub <= ISS_SUB_CMD2) || (sub == ISS_SUB_DISARM) ||
                  (sub == ISS_SUB_ARM);                           // [RULE_23]
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Serial engine.

  iss_state_t  state_reg;
  iss_state_t  state_next;
  logic [7:0]  shift_reg;
  logic [7:0]  shift_next;
  logic [3:0]  bit_reg;
  logic [3:0]  bit_next;
  logic [7:0]  ptr_reg;
  logic [7:0]  ptr_next;
  logic        odd_reg;
  logic        odd_next;
  logic        sda_out_reg;
  logic        sda_out_next;
  logic        sda_oe_reg;
  logic        sda_oe_next;
  logic        wr_en;
  logic        arm_pulse;
  logic        disarm_pulse;
  logic [7:0]  tx_byte;
  logic [7:0]  rf_rd;

  // Read data: commands come from the register file, status from inputs.
  always_comb begin
    if (ptr_reg >= ISS_SUB_STAT0 && ptr_reg <= ISS_SUB_STAT2) begin
      tx_byte = status_flat[(ptr_reg - ISS_SUB_STAT0) * 8 +: 8];  // [RULE_15]
    end else if (ptr_reg == ISS_SUB_ARM) begin
      tx_byte = 8'hFF;                                            // [RULE_03]
    end else begin
      tx_byte = rf_rd;
    end
  end

  // Byte receive, acknowledge and transmit sequencing.
  always_comb begin
    state_next   = state_reg;
    shift_next   = shift_reg;
    bit_next     = bit_reg;
    ptr_next     = ptr_reg;
    odd_next     = odd_reg;
    sda_out_next = 1'b0;                                          // [RULE_10]
    sda_oe_next  = sda_oe_reg;
    wr_en        = 1'b0;
    arm_pulse    = 1'b0;
    disarm_pulse = 1'b0;
    if (start_det) begin
      // Repeated START resets framing only; pending data is kept.
      state_next  = ISS_ADDR;                                     // [RULE_18]
      bit_next    = 4'h0;
      sda_oe_next = 1'b0;
    end else if (stop_det) begin
      state_next  = ISS_IDLE;
      sda_oe_next = 1'b0;
    end else begin
      case (state_reg)
        ISS_ADDR, ISS_WR_BYTE: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_f};                 // [RULE_09]
            bit_next   = bit_reg + 4'h1;
          end else if (scl_fall && bit_reg == ISS_BITS_PER_BYTE) begin
            if (state_reg == ISS_ADDR) begin
              if (shift_reg == ISS_ADDR_WR || shift_reg == ISS_ADDR_RD) begin
                sda_oe_next = 1'b1;                               // [RULE_14]
                state_next  = ISS_ADDR_ACK;
              end else begin
                state_next  = ISS_IDLE;
              end
            end else begin
              sda_oe_next = 1'b1;                                 // [RULE_11]
              state_next  = ISS_WR_ACK;
            end
          end
        end
        ISS_ADDR_ACK: begin
          if (scl_fall) begin
            bit_next = 4'h0;
            odd_next = 1'b1;
            if (shift_reg[0]) begin
              state_next  = ISS_RD_BYTE;
              shift_next  = tx_byte;
              sda_oe_next = ~tx_byte[7];
            end else begin
              state_next  = ISS_WR_BYTE;
              sda_oe_next = 1'b0;
            end
          end
        end
        ISS_WR_ACK: begin
          // Acknowledge held low through the ninth high phase.
          if (scl_fall) begin                                     // [RULE_12]
            sda_oe_next = 1'b0;
            bit_next    = 4'h0;
            odd_next    = ~odd_reg;
            state_next  = ISS_WR_BYTE;
            if (odd_reg) begin
              ptr_next = shift_reg;                               // [RULE_16]
            end else if (is_writable(ptr_reg)) begin              // [RULE_24]
              wr_en        = (ptr_reg != ISS_SUB_ARM);            // [RULE_17]
              arm_pulse    = (ptr_reg == ISS_SUB_ARM);            // [RULE_01]
              disarm_pulse = (ptr_reg == ISS_SUB_DISARM);         // [RULE_04]
            end
          end
        end
        ISS_RD_BYTE: begin
          if (scl_fall) begin
            bit_next = bit_reg + 4'h1;
            if (bit_reg == ISS_BITS_PER_BYTE - 4'h1) begin
              sda_oe_next = 1'b0;                                 // [RULE_13]
              state_next  = ISS_RD_ACK;
            end else begin
              shift_next  = {shift_reg[6:0], 1'b1};
              sda_oe_next = ~shift_reg[6];
            end
          end
        end
        ISS_RD_ACK: begin
          if (scl_fall) begin
            state_next = ISS_RD_DONE;
          end
        end
        ISS_RD_DONE: begin
          sda_oe_next = 1'b0;                                     // [RULE_22]
        end
        default: begin
          sda_oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg   <= ISS_IDLE;                                    // [RULE_06]
      shift_reg   <= 8'h00;
      bit_reg     <= 4'h0;
      ptr_reg     <= ISS_PTR_RESET;
      odd_reg     <= 1'b1;
      sda_out_reg <= 1'b0;
      sda_oe_reg  <= 1'b0;
    end else begin
      state_reg   <= state_next;
      shift_reg   <= shift_next;
      bit_reg     <= bit_next;
      ptr_reg     <= ptr_next;
      odd_reg     <= odd_next;
      sda_out_reg <= sda_out_next;
      sda_oe_reg  <= sda_oe_next;
    end
  end

  assign sda_out = sda_out_reg;
  assign sda_oe  = sda_oe_reg;

  //////////////////////////////////////////////////////////////////////////
  // Command registers.

  logic [31:0] act_flat;
  logic [31:0] cmd_reg;

  iss_regfile #(.N(ISS_NUM_CMD)) u_regs (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .wr_en       (wr_en),
    .wr_idx      (cmd_index(ptr_reg)),
    .wr_data     (shift_reg),
    .commit      (stop_det),                                      // [RULE_19]
    .rd_idx      (cmd_index(ptr_reg)),
    .rd_data     (rf_rd),
    .active_flat (act_flat)
  );

  // Register the active contents so the port comes from a flip-flop.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_reg <= 32'h0000_0000;
    end else begin
      cmd_reg <= act_flat;
    end
  end

  assign cmd_active = cmd_reg;

  //////////////////////////////////////////////////////////////////////////
  // Ship-and-store mode.

  logic pwr_s1_reg;
  logic pwr_s2_reg;
  logic pwr_s3_reg;
  logic pwr_reg;
  logic pwr_next;
  logic armed_reg;
  logic armed_next;
  logic active_reg;
  logic active_next;
  logic gate_reg;

  // Power-good is a pin level; three flops, change on stages two and three.
  always_comb begin
    pwr_next = (pwr_s2_reg == pwr_s3_reg) ? pwr_s3_reg : pwr_reg;
  end

  // Arming and activation; power return or a disarm write ends the mode,
  // while a fresh arm write in the same cycle keeps the arming, so set wins.
  always_comb begin
    armed_next  = armed_reg;
    active_next = active_reg;
    if (arm_pulse) begin
      armed_next = 1'b1;                                          // [RULE_01]
    end
    if (armed_next && !pwr_reg) begin
      active_next = 1'b1;                                         // [RULE_02]
    end
    if (disarm_pulse || pwr_reg) begin
      active_next = 1'b0;                                         // [RULE_04]
      armed_next  = armed_next & ~disarm_pulse;
    end
    if (active_reg && pwr_reg && !arm_pulse) begin
      armed_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwr_s1_reg <= 1'b0;
      pwr_s2_reg <= 1'b0;
      pwr_s3_reg <= 1'b0;
      pwr_reg    <= 1'b0;
      armed_reg  <= 1'b0;
      active_reg <= 1'b0;
      gate_reg   <= 1'b0;
    end else begin
      pwr_s1_reg <= input_power_good;
      pwr_s2_reg <= pwr_s1_reg;
      pwr_s3_reg <= pwr_s2_reg;
      pwr_reg    <= pwr_next;
      armed_reg  <= armed_next;
      active_reg <= active_next;
      gate_reg   <= active_next;                                  // [RULE_05]
    end
  end

  assign ship_armed    = armed_reg;
  assign ship_active   = active_reg;
  assign batt_gate_off = gate_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_arm;
    @(posedge clk) disable iff (sys_rst) arm_pulse |=> armed_reg | active_reg;
  endproperty
  a_arm: assert property (p_arm) else $error("arm write did not arm"); // [RULE_01]

  property p_activate;
    @(posedge clk) disable iff (sys_rst)
      (armed_reg && !pwr_reg && !disarm_pulse) |=> active_reg;
  endproperty
  a_activate: assert property (p_activate) else $error("ship mode not active"); // [RULE_02]

  property p_leave;
    @(posedge clk) disable iff (sys_rst) (pwr_reg || disarm_pulse) |=> !active_reg;
  endproperty
  a_leave: assert property (p_leave) else $error("ship mode not left"); // [RULE_04]

  property p_gate;
    @(posedge clk) disable iff (sys_rst) ship_active |-> batt_gate_off;
  endproperty
  a_gate: assert property (p_gate) else $error("gate does not follow mode"); // [RULE_05]

  property p_no_sda_high;
    @(posedge clk) disable iff (sys_rst) sda_oe |-> !sda_out;
  endproperty
  a_no_sda_high: assert property (p_no_sda_high) else $error("sda driven high"); // [RULE_10]

  sequence s_rd_ack_released;
    (state_reg == ISS_RD_ACK) ##1 (state_reg == ISS_RD_ACK);
  endsequence
  property p_rd_release;
    @(posedge clk) disable iff (sys_rst) s_rd_ack_released |-> !sda_oe;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("sda held in read ack"); // [RULE_13]

  property p_done_release;
    @(posedge clk) disable iff (sys_rst) (state_reg == ISS_RD_DONE) |=> !sda_oe;
  endproperty
  a_done_release: assert property (p_done_release) else $error("sda held after byte"); // [RULE_22]

  property p_ack_hold;
    @(posedge clk) disable iff (sys_rst)
      (state_reg == ISS_WR_ACK && scl_rise) |-> sda_oe;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack not held"); // [RULE_12]

  property p_ptr_keep;
    @(posedge clk) disable iff (sys_rst) stop_det |=> $stable(ptr_reg);
  endproperty
  a_ptr_keep: assert property (p_ptr_keep) else $error("pointer lost at stop"); // [RULE_16]

endmodule

// File: iss_bus_master.sv
/*
  Behavioural two-wire bus master for the slave bench.
  Assumes a pull-up on both lines; the bench resolves SDA from all drivers.
*/
module iss_bus_master (
  // Bus lines, 1 = released.
  output logic      scl,
  output logic      sda_drv,
  // Resolved SDA level.
  input  wire logic sda_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quarter of a 400 kHz period, the top bus rate the slave is built for.
  localparam int Q = 625;

  // Both lines idle released high.
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Start or repeated start: SDA falls while SCL is high.
  task automatic start();
    sda_drv = 1'b1;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask

  // Stop: SDA rises while SCL is high.
  task automatic stop();
    sda_drv = 1'b0;
    #Q scl = 1'b1;
    #Q sda_drv = 1'b1;
    #(2 * Q);
  endtask

  // One clock: data set mid-low, sampled mid-high, master owns the fall.
  task automatic bit_x(input logic b, output logic r);
    sda_drv = b;
    #Q scl = 1'b1;
    #Q r = sda_bus;
    #Q scl = 1'b0;
    #Q;
  endtask

  // Byte out MSB first, then release SDA for the ninth clock.
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  // Byte in, then acknowledge or not on the ninth clock.
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(~mack, r);
  endtask
endmodule

// File: test_i2c_subaddr_slave_ship_store.sv
/*
  Self-checking bench for the sub-addressed slave with ship-and-store.
  Assumes the bus master model in its own file and the design package.
*/
module test_i2c_subaddr_slave_ship_store import iss_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 90000;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        pwr = 1'b1;
  logic [23:0] status_flat = 24'hC3_5A_81;
  logic        scl;
  logic        sda_drv;
  logic        sda_out;
  logic        sda_oe;
  logic        ship_armed;
  logic        ship_active;
  logic        batt_gate_off;
  logic [31:0] cmd_active;
  logic [7:0]  d;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  // Open-drain wire: low if any party pulls, else the pull-up wins.
  wire         sda_bus = sda_drv & ~(sda_oe & ~sda_out);

  iss_slave #(.FILT_CYC(ISS_GLITCH_CYC)) i_iss_slave (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_bus),
    .sda_out(sda_out), .sda_oe(sda_oe), .input_power_good(pwr),
    .status_flat(status_flat), .ship_armed(ship_armed),
    .ship_active(ship_active), .batt_gate_off(batt_gate_off),
    .cmd_active(cmd_active));
  iss_bus_master u_master (.scl(scl), .sda_drv(sda_drv), .sda_bus(sda_bus));

  //////////////////////////////////////////////////////////////////////////
  // Clock and hang guard.
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      conclude();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Shared tasks.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [7:0] b);
    logic ack;
    u_master.wr_byte(b, ack);
    chk(ack, 1'b1);
  endtask
  task automatic wr_pair(input logic [7:0] p, input logic [7:0] v);
    u_master.start();
    send(ISS_ADDR_WR);
    send(p);
    send(v);
    u_master.stop();
    wait_clk(4);
  endtask
  task automatic ship_is(input logic [2:0] exp);
    chk({ship_armed, ship_active, batt_gate_off}, exp);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Two staged pairs, repeated start, read back pending, then commit.
  task automatic t_stage();
    u_master.start();
    send(ISS_ADDR_WR);
    send(ISS_SUB_CMD0);
    send(8'hA5);
    send(ISS_SUB_CMD1);
    send(8'h3C);
    u_master.start();
    send(ISS_ADDR_RD);
    u_master.rd_byte(1'b1, d);
    chk(d, 8'h3C);
    u_master.rd_byte(1'b0, d);
    chk(d, 8'hFF);
    chk(cmd_active, 32'h0);
    u_master.stop();
    wait_clk(4);
    chk(cmd_active, 32'h0000_3CA5);
  endtask

  // Write into a status location is dropped; the status byte reads back.
  task automatic t_status();
    u_master.start();
    send(ISS_ADDR_WR);
    send(ISS_SUB_CMD2);
    send(8'h96);
    send(ISS_SUB_STAT1);
    send(8'h55);
    u_master.start();
    send(ISS_ADDR_RD);
    u_master.rd_byte(1'b0, d);
    chk(d, 8'h5A);
    u_master.stop();
    wait_clk(4);
    chk(cmd_active, 32'h0096_3CA5);
  endtask

  // A foreign address gets no acknowledge.
  task automatic t_addr();
    logic ack;
    u_master.start();
    u_master.wr_byte(8'h20, ack);
    chk(ack, 1'b0);
    u_master.stop();
  endtask

  // Arm with power, lose power, read the arm location, disarm, rearm.
  task automatic t_ship();
    wr_pair(ISS_SUB_ARM, 8'h5E);
    ship_is(3'b100);
    @(posedge clk);
    #1 pwr = 1'b0;
    wait_clk(8);
    ship_is(3'b111);
    u_master.start();
    send(ISS_ADDR_WR);
    send(ISS_SUB_ARM);
    u_master.start();
    send(ISS_ADDR_RD);
    u_master.rd_byte(1'b0, d);
    u_master.stop();
    wait_clk(4);
    ship_is(3'b111);
    wr_pair(ISS_SUB_DISARM, 8'h81);
    ship_is(3'b000);
    chk(cmd_active[31:24], 8'h81);
    wr_pair(ISS_SUB_ARM, 8'h00);
    ship_is(3'b111);
    @(posedge clk);
    #1 pwr = 1'b1;
    wait_clk(8);
    chk({ship_active, batt_gate_off}, 2'b00);
  endtask

  // Supply lockout in mid-run clears arming and the command set.
  task automatic t_reset();
    wr_pair(ISS_SUB_ARM, 8'h00);
    ship_is(3'b100);
    sys_rst = 1'b1;
    wait_clk(2);
    sys_rst = 1'b0;
    wait_clk(4);
    ship_is(3'b000);
    chk(cmd_active, 32'h0);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence: four cycles of reset, then the scenarios.
  initial begin
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'b0;
    wait_clk(20);
    t_stage();
    t_status();
    t_addr();
    t_ship();
    t_reset();
    conclude();
  end
endmodule
